// >>> hw/spcu_pkg.sv
`default_nettype none
// ****************************************************************
// Shared constants for the serial port configuration block.
// ****************************************************************
package spcu_pkg;
  // Core clock rate and documented line rates in bits per second.
  localparam int unsigned CLK_HZ     = 50_000_000;
  localparam int unsigned RATE_300   = 300;
  localparam int unsigned RATE_1200  = 1200;
  localparam int unsigned RATE_9600  = 9600;
  localparam int unsigned RATE_19K2  = 19_200;
  // Core clock cycles per bit for each rate.
  localparam logic [17:0] BIT_CYC_300  = 18'(CLK_HZ / RATE_300);
  localparam logic [17:0] BIT_CYC_1200 = 18'(CLK_HZ / RATE_1200);
  localparam logic [17:0] BIT_CYC_9600 = 18'(CLK_HZ / RATE_9600);
  localparam logic [17:0] BIT_CYC_19K2 = 18'(CLK_HZ / RATE_19K2);
  // Transmit turn-around delay in milliseconds and in cycles.
  localparam int unsigned TURN_MS  = 10;
  localparam logic [18:0] TURN_CYC = 19'(CLK_HZ / 1000 * TURN_MS);
  // Register byte addresses.
  localparam logic [7:0] ADDR_DATA   = 8'h00;
  localparam logic [7:0] ADDR_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ISTAT  = 8'h0C;
  localparam logic [7:0] ADDR_IMASK  = 8'h10;
  localparam logic [7:0] ADDR_CONFIG = 8'h14;
  // Configuration switch positions, switch 1 at bit 0.
  localparam int unsigned SW_RATE   = 0;
  localparam int unsigned SW_PARITY = 2;
  localparam int unsigned SW_LOOP   = 3;
  localparam int unsigned SW_DELAY  = 4;
  localparam int unsigned SW_KEY    = 5;
  // Valid unit address range.
  localparam logic [7:0] UNIT_MIN = 8'h01;
  localparam logic [7:0] UNIT_MAX = 8'h5A;
  // Interrupt status bit positions.
  localparam int unsigned IRQ_RX  = 0;
  localparam int unsigned IRQ_TX  = 1;
  localparam int unsigned IRQ_PAR = 2;
  localparam int unsigned IRQ_FRM = 3;
  localparam int unsigned IRQ_OVR = 4;
  localparam int unsigned IRQ_W   = 5;
  // Values after reset.
  localparam logic [IRQ_W-1:0] IMASK_RST = 5'h00;
  localparam logic [10:0]      TX_SH_RST = 11'h7FF;
  // Bits left after the start bit, with and without parity; the stop bit counts for transmit only.
  localparam logic [3:0] TX_BITS_PAR = 4'hA;
  localparam logic [3:0] TX_BITS_NOP = 4'h9;
  localparam logic [3:0] RX_BITS_PAR = 4'h9;
  localparam logic [3:0] RX_BITS_NOP = 4'h8;
  typedef enum logic [1:0] {T_IDLE, T_DELAY, T_WAIT, T_SEND} spcu_tx_t;
  typedef enum logic [1:0] {R_IDLE, R_START, R_DATA, R_STOP} spcu_rx_t;
endpackage
`default_nettype wire

// >>> hw/spcu_top.sv
// Decided for this implementation: the strobed register port and the placing of the registers.
`default_nettype none
// Overview of operation
// - Two switches choose one of four bit rates.
// - Parity switch enables odd parity both directions.
// - Switch 4 loops back, only while offline.
// - Switch 5 adds a 10 ms turn-around.
// - A switch gates the keying output.
// - Eight switches give unit address 1..90.
// - Link comes up at power only if online.
// - Logic one is mark; idle line is mark.
// - Raise RTS, delay, send with CTS, drop.
// - CTS loss pauses at boundary; receive ignores handshakes.
module spcu_top #(
  parameter logic [17:0] P_BIT_300  = spcu_pkg::BIT_CYC_300,
  parameter logic [17:0] P_BIT_1200 = spcu_pkg::BIT_CYC_1200,
  parameter logic [17:0] P_BIT_9600 = spcu_pkg::BIT_CYC_9600,
  parameter logic [18:0] P_TURN     = spcu_pkg::TURN_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  cfg_sw,
  input  wire logic [7:0]  addr_sw,
  input  wire logic        online_i,
  input  wire logic        cpu_run_i,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             rts_o,
  input  wire logic        cts_i,
  output logic             key_o,
  output logic             link_en_o,
  output logic             term_led_o,
  output logic      [7:0]  unit_addr_o,
  output logic             addr_valid_o,
  output logic             irq_o
);
  // ****************************************************************
  // Switch decoding
  // ****************************************************************
  // Cycles per bit for a rate selection; used by both directions.
  function automatic logic [17:0] bit_cyc(input logic [1:0] sel);
    case (sel)
      2'h0:    bit_cyc = P_BIT_300;
      2'h1:    bit_cyc = P_BIT_1200;
      2'h2:    bit_cyc = P_BIT_9600;
      default: bit_cyc = spcu_pkg::BIT_CYC_19K2;
    endcase
  endfunction

  localparam int unsigned IRQ_W_L = spcu_pkg::IRQ_W;
  logic [1:0]          rate_sel;
  logic                par_en;
  logic                dly_en;
  logic                loop_act;
  logic [17:0]         bc;
  spcu_pkg::spcu_tx_t  tx_st_q;
  spcu_pkg::spcu_rx_t  rx_st_q;
  logic [18:0]         tx_dly_q;
  logic [17:0]         tx_cnt_q;
  logic [3:0]          tx_bits_q;
  logic [10:0]         tx_sh_q;
  logic [7:0]          hold_q;
  logic                hold_full_q;
  logic                tx_load;
  logic                ctrl_blk_q;
  logic [17:0]         rx_cnt_q;
  logic [3:0]          rx_bits_q;
  logic [8:0]          rx_sh_q;
  logic                rx_line;
  logic                rx_done;
  logic [7:0]          rx_data_q;
  logic                rx_full_q;
  logic                link_q;
  logic                boot_q;
  logic                online_q;
  logic [IRQ_W_L-1:0]  istat_q;
  logic [IRQ_W_L-1:0]  imask_q;
  logic [IRQ_W_L-1:0]  ev;
  logic                wr_data;
  logic                rd_data;

  // Rate selection is {switch 2, switch 1}.
  assign rate_sel     = cfg_sw[spcu_pkg::SW_RATE +: 2];
  assign bc           = bit_cyc(rate_sel);
  assign par_en       = cfg_sw[spcu_pkg::SW_PARITY];
  assign dly_en       = cfg_sw[spcu_pkg::SW_DELAY];
  // Loop-back is refused while online so live traffic is never echoed.
  assign loop_act     = cfg_sw[spcu_pkg::SW_LOOP] & ~online_i;
  assign rx_line      = loop_act ? tx_sh_q[0] : rxd_i;
  assign unit_addr_o  = addr_sw;
  assign addr_valid_o = (addr_sw >= spcu_pkg::UNIT_MIN) && (addr_sw <= spcu_pkg::UNIT_MAX);

  // ****************************************************************
  // Link enable and terminal indicator
  // ****************************************************************
  // The power-up state is sampled on the first edge after reset; the
  // link later needs an offline-to-online move with the CPU in run.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boot_q   <= 1'b0;
      link_q   <= 1'b0;
      online_q <= 1'b0;
    end else begin
      boot_q   <= 1'b1;
      online_q <= online_i;
      if (!boot_q) begin
        link_q <= online_i & cpu_run_i;
      end else if (!online_i || !cpu_run_i) begin
        link_q <= 1'b0;
      end else if (!online_q) begin
        link_q <= 1'b1;
      end
    end
  end
  assign link_en_o  = link_q;
  assign term_led_o = link_q;

  // ****************************************************************
  // Transmitter
  // ****************************************************************
  assign tx_load = (tx_st_q == spcu_pkg::T_WAIT) & ctrl_blk_q & hold_full_q & cts_i;

  // Handshake sequence and character shifter; idle shifter is all ones.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_st_q   <= spcu_pkg::T_IDLE;
      tx_dly_q  <= '0;
      tx_cnt_q  <= '0;
      tx_bits_q <= '0;
      tx_sh_q   <= spcu_pkg::TX_SH_RST;
    end else begin
      case (tx_st_q)
        spcu_pkg::T_IDLE: begin
          if (ctrl_blk_q) begin
            tx_dly_q <= P_TURN - 19'h00001;
            tx_st_q  <= dly_en ? spcu_pkg::T_DELAY : spcu_pkg::T_WAIT;
          end
        end
        spcu_pkg::T_DELAY: begin
          if (!ctrl_blk_q) begin
            tx_st_q <= spcu_pkg::T_IDLE;
          end else if (tx_dly_q == '0) begin
            tx_st_q <= spcu_pkg::T_WAIT;
          end else begin
            tx_dly_q <= tx_dly_q - 19'h00001;
          end
        end
        spcu_pkg::T_WAIT: begin
          if (!ctrl_blk_q) begin
            tx_st_q <= spcu_pkg::T_IDLE;
          end else if (tx_load) begin
            // Stop, parity or second stop, data, start.
            tx_sh_q   <= {1'b1, (par_en ? ~^hold_q : 1'b1), hold_q, 1'b0};
            tx_bits_q <= par_en ? spcu_pkg::TX_BITS_PAR : spcu_pkg::TX_BITS_NOP;
            tx_cnt_q  <= bc - 18'h00001;
            tx_st_q   <= spcu_pkg::T_SEND;
          end
        end
        spcu_pkg::T_SEND: begin
          if (tx_cnt_q != '0) begin
            tx_cnt_q <= tx_cnt_q - 18'h00001;
          end else if (tx_bits_q == '0) begin
            tx_st_q <= spcu_pkg::T_WAIT;
          end else begin
            tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
            tx_bits_q <= tx_bits_q - 4'h1;
            tx_cnt_q  <= bc - 18'h00001;
          end
        end
        default: tx_st_q <= spcu_pkg::T_IDLE;
      endcase
    end
  end
  assign txd_o = tx_sh_q[0];
  assign rts_o = (tx_st_q != spcu_pkg::T_IDLE);
  assign key_o = rts_o & cfg_sw[spcu_pkg::SW_KEY];

  // ****************************************************************
  // Receiver
  // ****************************************************************
  // Samples at mid-bit; takes no notice of RTS or CTS.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_st_q   <= spcu_pkg::R_IDLE;
      rx_cnt_q  <= '0;
      rx_bits_q <= '0;
      rx_sh_q   <= '0;
    end else begin
      case (rx_st_q)
        spcu_pkg::R_IDLE: begin
          if (!rx_line) begin
            rx_cnt_q <= {1'b0, bc[17:1]} - 18'h00001;
            rx_st_q  <= spcu_pkg::R_START;
          end
        end
        spcu_pkg::R_START: begin
          if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 18'h00001;
          end else if (rx_line) begin
            rx_st_q <= spcu_pkg::R_IDLE;
          end else begin
            rx_cnt_q  <= bc - 18'h00001;
            rx_bits_q <= par_en ? spcu_pkg::RX_BITS_PAR : spcu_pkg::RX_BITS_NOP;
            rx_st_q   <= spcu_pkg::R_DATA;
          end
        end
        spcu_pkg::R_DATA: begin
          if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 18'h00001;
          end else begin
            rx_sh_q   <= {rx_line, rx_sh_q[8:1]};
            rx_bits_q <= rx_bits_q - 4'h1;
            rx_cnt_q  <= bc - 18'h00001;
            if (rx_bits_q == 4'h1) begin
              rx_st_q <= spcu_pkg::R_STOP;
            end
          end
        end
        spcu_pkg::R_STOP: begin
          if (rx_cnt_q != '0) begin
            rx_cnt_q <= rx_cnt_q - 18'h00001;
          end else begin
            rx_st_q <= spcu_pkg::R_IDLE;
          end
        end
        default: rx_st_q <= spcu_pkg::R_IDLE;
      endcase
    end
  end
  assign rx_done = (rx_st_q == spcu_pkg::R_STOP) && (rx_cnt_q == '0);

  // Events; parity is odd over data and parity bit together.
  always_comb begin
    ev                   = '0;
    ev[spcu_pkg::IRQ_RX]  = rx_done;
    ev[spcu_pkg::IRQ_TX]  = tx_load;
    ev[spcu_pkg::IRQ_PAR] = rx_done & par_en & ~(^rx_sh_q);
    ev[spcu_pkg::IRQ_FRM] = rx_done & ~rx_line;
    ev[spcu_pkg::IRQ_OVR] = rx_done & rx_full_q;
  end

  // ****************************************************************
  // Register port and interrupts
  // ****************************************************************
  assign wr_data = reg_wr && (reg_addr == spcu_pkg::ADDR_DATA);
  assign rd_data = reg_rd && (reg_addr == spcu_pkg::ADDR_DATA);

  // Transmit holding and receive data; a write to a full holder is dropped.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hold_q      <= '0;
      hold_full_q <= 1'b0;
      rx_data_q   <= '0;
      rx_full_q   <= 1'b0;
    end else begin
      if (wr_data && !hold_full_q) begin
        hold_q      <= reg_wdata[7:0];
        hold_full_q <= 1'b1;
      end else if (tx_load) begin
        hold_full_q <= 1'b0;
      end
      // A new character beats a read in the same cycle.
      if (rx_done) begin
        rx_data_q <= par_en ? rx_sh_q[7:0] : rx_sh_q[8:1];
        rx_full_q <= 1'b1;
      end else if (rd_data) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  // Control, mask and sticky status; a set outranks a clear by write.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_blk_q <= 1'b0;
      imask_q    <= spcu_pkg::IMASK_RST;
      istat_q    <= '0;
    end else begin
      if (reg_wr && reg_addr == spcu_pkg::ADDR_CTRL) begin
        ctrl_blk_q <= reg_wdata[0];
      end
      if (reg_wr && reg_addr == spcu_pkg::ADDR_IMASK) begin
        imask_q <= reg_wdata[IRQ_W_L-1:0];
      end
      if (reg_wr && reg_addr == spcu_pkg::ADDR_ISTAT) begin
        istat_q <= (istat_q & ~reg_wdata[IRQ_W_L-1:0]) | ev;
      end else begin
        istat_q <= istat_q | ev;
      end
    end
  end
  assign irq_o = |(istat_q & imask_q);

  // Read data stands for one cycle after the strobe; others read zero.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (!reg_rd) begin
      reg_rdata <= '0;
    end else begin
      case (reg_addr)
        spcu_pkg::ADDR_DATA:   reg_rdata <= {24'h000000, rx_data_q};
        spcu_pkg::ADDR_CTRL:   reg_rdata <= {31'h00000000, ctrl_blk_q};
        spcu_pkg::ADDR_STATUS: reg_rdata <= {25'h0000000, loop_act, link_q, cts_i, rts_o,
                                             (tx_st_q == spcu_pkg::T_SEND), rx_full_q, hold_full_q};
        spcu_pkg::ADDR_ISTAT:  reg_rdata <= {27'h0000000, istat_q};
        spcu_pkg::ADDR_IMASK:  reg_rdata <= {27'h0000000, imask_q};
        spcu_pkg::ADDR_CONFIG: reg_rdata <= {16'h0000, cfg_sw[7:0], addr_valid_o, 7'h00} << 0 |
                                            {24'h000000, addr_sw};
        default:               reg_rdata <= '0;
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_rate_19k2;
    @(posedge core_clk) disable iff (rst)
      (tx_st_q == spcu_pkg::T_WAIT) && tx_load && (rate_sel == 2'h3) |=> (tx_cnt_q == 18'h00A2B);
  endproperty
  a_rate_19k2: assert property (p_rate_19k2) else $error("bit period wrong at 19.2k");

  property p_par_bit;
    @(posedge core_clk) disable iff (rst)
      tx_load && par_en |=> (tx_sh_q[9] == ~^tx_sh_q[8:1]);
  endproperty
  a_par_bit: assert property (p_par_bit) else $error("transmit parity not odd");

  property p_loop;
    @(posedge core_clk) disable iff (rst)
      online_i |-> (rx_line == rxd_i);
  endproperty
  a_loop: assert property (p_loop) else $error("loop-back active while online");

  property p_delay;
    @(posedge core_clk) disable iff (rst)
      $rose(rts_o) && dly_en |-> (tx_st_q == spcu_pkg::T_DELAY) && (tx_dly_q == P_TURN - 19'h00001);
  endproperty
  a_delay: assert property (p_delay) else $error("turn-around delay not started");

  property p_key;
    @(posedge core_clk) disable iff (rst)
      !cfg_sw[spcu_pkg::SW_KEY] |-> !key_o;
  endproperty
  a_key: assert property (p_key) else $error("keying output while disabled");

  property p_link_off;
    @(posedge core_clk) disable iff (rst)
      !online_i |=> !link_en_o;
  endproperty
  a_link_off: assert property (p_link_off) else $error("link enabled while offline");

  property p_idle_mark;
    @(posedge core_clk) disable iff (rst)
      (tx_st_q != spcu_pkg::T_SEND) |-> txd_o;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("line not at mark between characters");

  property p_cts_gate;
    @(posedge core_clk) disable iff (rst)
      (tx_st_q == spcu_pkg::T_WAIT) && !cts_i |=> (tx_st_q != spcu_pkg::T_SEND);
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("character started without CTS");

  property p_start_bit;
    @(posedge core_clk) disable iff (rst)
      tx_load |=> !txd_o && rts_o;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit missing");

  property p_rts_drop;
    @(posedge core_clk) disable iff (rst)
      !ctrl_blk_q && (tx_st_q == spcu_pkg::T_WAIT) |=> !rts_o;
  endproperty
  a_rts_drop: assert property (p_rts_drop) else $error("RTS held after block end");
endmodule
`default_nettype wire

// >>> dv/spcu_far_end.sv
`default_nettype none
// ****************************************************************
// Far-end serial master model.
// ****************************************************************
module spcu_far_end (
  input  wire logic core_clk,
  input  wire logic txd_i,
  input  wire logic rts_i,
  input  wire logic cts_allow_i,  // The testbench withholds clear-to-send through this.
  output logic      rxd_o,
  output logic      cts_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // A fail-safe receiver and an idle sender both leave the line at mark.
  initial begin
    rxd_o = 1'b1;
  end

  // Clear-to-send is never granted without a raised request, so it falls whenever the request does.
  assign cts_o = rts_i & cts_allow_i;

  // Sends one character; each bit is held for the whole bit time, then the line returns to mark.
  task automatic send_byte(input logic [7:0] data, input logic par_en, input logic bad_par, input int bit_cyc);
    logic [10:0] frame;
    int          n;
    frame = {1'b1, (~^data) ^ bad_par, data, 1'b0};
    n = par_en ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk);
      rxd_o <= (i == n - 1) ? 1'b1 : frame[i];
      repeat (bit_cyc - 1) @(posedge core_clk);
    end
  endtask

  // Receives one character by mid-bit sampling; a wrong bit rate garbles the data or the stop bit.
  task automatic recv_byte(input int bit_cyc, input logic par_en, output logic [7:0] data, output logic par,
                           output logic stop_ok);
    int   wait_n;
    logic start_mid;
    wait_n = 0;
    par = 1'b0;
    while (txd_i !== 1'b0 && wait_n < 100000) begin
      @(posedge core_clk);
      wait_n++;
    end
    repeat (bit_cyc / 2) @(posedge core_clk);
    start_mid = txd_i;
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge core_clk);
      data[i] = txd_i;
    end
    if (par_en) begin
      repeat (bit_cyc) @(posedge core_clk);
      par = txd_i;
    end
    repeat (bit_cyc) @(posedge core_clk);
    stop_ok = txd_i & ~start_mid;
  endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`default_nettype none
// ****************************************************************
// Self-checking bench for the serial port configuration block.
// ****************************************************************
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;
  logic        rst;
  logic [7:0]  cfg_sw;
  logic [7:0]  addr_sw;
  logic        online;
  logic        cpu_run;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        rxd;
  logic        txd;
  logic        rts;
  logic        cts;
  logic        cts_allow;
  logic        key;
  logic        link_en;
  logic        term_led;
  logic [7:0]  unit_addr;
  logic        addr_valid;
  logic        irq;
  int          err_total;
  int          check_count;
  logic [31:0] v;
  logic [7:0]  got;
  logic        par;
  logic        stop_ok;
  int          n;
  // Short bit times keep the run brief; the fastest rate has no parameter and runs at full length.
  int          bit_tab [4] = '{32'h28, 32'h20, 32'h18, int'(spcu_pkg::BIT_CYC_19K2)};
  logic [7:0]  addr_tab [5] = '{8'h00, 8'h01, 8'h5A, 8'h5B, 8'hFF};

  spcu_top #(.P_BIT_300(18'h28), .P_BIT_1200(18'h20), .P_BIT_9600(18'h18), .P_TURN(19'h64)) DUT (
    .core_clk(core_clk), .rst(rst), .cfg_sw(cfg_sw), .addr_sw(addr_sw), .online_i(online),
    .cpu_run_i(cpu_run), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rxd_i(rxd), .txd_o(txd), .rts_o(rts), .cts_i(cts), .key_o(key),
    .link_en_o(link_en), .term_led_o(term_led), .unit_addr_o(unit_addr), .addr_valid_o(addr_valid),
    .irq_o(irq));

  spcu_far_end far (.core_clk(core_clk), .txd_i(txd), .rts_i(rts), .rxd_o(rxd), .cts_o(cts),
                    .cts_allow_i(cts_allow));

  // The clock toggles every half period of 20 ns.
  always #10 core_clk = ~core_clk;

  // ****************************************************************
  // Bus cycles and comparison helpers.
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
    check_count++;
    if (got_v !== exp_v) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
    end
  endtask

  // Sends one byte, lets the far end receive it, then ends the block and waits for the request to drop.
  task automatic tx_char(input logic [7:0] b, input int bc, input logic pe);
    wr(spcu_pkg::ADDR_CTRL, 32'h0000_0001);
    wr(spcu_pkg::ADDR_DATA, {24'h000000, b});
    far.recv_byte(bc, pe, got, par, stop_ok);
    wr(spcu_pkg::ADDR_CTRL, 32'h0000_0000);
    n = 0;
    while (rts !== 1'b0 && n < 4 * bc) begin
      @(posedge core_clk);
      n++;
    end
    chk(rts, 1'b0);
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // The whole sequence needs about 31k cycles, most of it the full-length fast character.
  initial begin
    repeat (80000) @(posedge core_clk);
    err_total++;
    summarize();
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    cfg_sw = 8'h00;
    addr_sw = 8'h01;
    online = 1'b1;
    cpu_run = 1'b1;
    cts_allow = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_total = 0;
    check_count = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk(txd, 1'b1);
    chk(rts, 1'b0);
    chk(link_en, 1'b1);
    chk(term_led, 1'b1);
    rd(spcu_pkg::ADDR_IMASK, v);
    chk(v, 32'h0000_0000);
    rd(8'h40, v);
    chk(v, 32'h0000_0000);
    // Address switches at and beyond both ends of the valid range.
    foreach (addr_tab[i]) begin
      @(posedge core_clk);
      addr_sw <= addr_tab[i];
      @(posedge core_clk);
      #1;
      chk(unit_addr, addr_tab[i]);
      chk(addr_valid, (addr_tab[i] >= 8'h01 && addr_tab[i] <= 8'h5A));
    end
    // Every rate code, each checked by mid-bit sampling of an uneven pattern.
    for (int r = 0; r < 4; r++) begin
      @(posedge core_clk);
      cfg_sw <= 8'(r);
      tx_char(8'h35, bit_tab[r], 1'b0);
      chk(got, 8'h35);
      chk(stop_ok, 1'b1);
    end
    // Odd parity on transmit.
    @(posedge core_clk);
    cfg_sw <= 8'h04;
    tx_char(8'h35, 40, 1'b1);
    chk({got, par}, {8'h35, ~^8'h35});
    // Turn-around delay with keying enabled: start bit no sooner than the delay.
    @(posedge core_clk);
    cfg_sw <= 8'h30;
    wr(spcu_pkg::ADDR_CTRL, 32'h0000_0001);
    wr(spcu_pkg::ADDR_DATA, 32'h0000_00A7);
    #1;
    chk(key, 1'b1);
    n = 0;
    while (txd === 1'b1 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    chk(n >= 99 && n <= 110, 1'b1);
    far.recv_byte(40, 1'b0, got, par, stop_ok);
    chk(got, 8'hA7);
    wr(spcu_pkg::ADDR_CTRL, 32'h0000_0000);
    // Clear-to-send withheld: no start bit, keying stays off with its switch off.
    @(posedge core_clk);
    cfg_sw <= 8'h00;
    cts_allow <= 1'b0;
    wr(spcu_pkg::ADDR_CTRL, 32'h0000_0001);
    wr(spcu_pkg::ADDR_DATA, 32'h0000_005E);
    repeat (200) @(posedge core_clk);
    #1;
    chk({rts, txd, key}, 3'h6);
    cts_allow <= 1'b1;
    far.recv_byte(40, 1'b0, got, par, stop_ok);
    chk(got, 8'h5E);
    wr(spcu_pkg::ADDR_CTRL, 32'h0000_0000);
    // Reception with both handshake lines false, plus the interrupt path.
    repeat (200) @(posedge core_clk);
    wr(spcu_pkg::ADDR_ISTAT, 32'h0000_001F);
    far.send_byte(8'hC6, 1'b0, 1'b0, 40);
    repeat (60) @(posedge core_clk);
    rd(spcu_pkg::ADDR_ISTAT, v);
    chk(v[0], 1'b1);
    chk(irq, 1'b0);
    wr(spcu_pkg::ADDR_IMASK, 32'h0000_0001);
    #1;
    chk(irq, 1'b1);
    rd(spcu_pkg::ADDR_DATA, v);
    chk(v[7:0], 8'hC6);
    wr(spcu_pkg::ADDR_ISTAT, 32'h0000_0001);
    #1;
    chk(irq, 1'b0);
    wr(spcu_pkg::ADDR_IMASK, 32'h0000_0000);
    // Received parity: a bad bit flags an error, a good one does not.
    @(posedge core_clk);
    cfg_sw <= 8'h04;
    far.send_byte(8'h35, 1'b1, 1'b1, 40);
    repeat (60) @(posedge core_clk);
    rd(spcu_pkg::ADDR_ISTAT, v);
    chk(v[2], 1'b1);
    rd(spcu_pkg::ADDR_DATA, v);
    wr(spcu_pkg::ADDR_ISTAT, 32'h0000_001F);
    far.send_byte(8'h35, 1'b1, 1'b0, 40);
    repeat (60) @(posedge core_clk);
    rd(spcu_pkg::ADDR_ISTAT, v);
    chk(v[2:0] & 3'h5, 3'h1);
    rd(spcu_pkg::ADDR_DATA, v);
    chk(v[7:0], 8'h35);
    // Loop-back runs only offline; going offline drops the link.
    @(posedge core_clk);
    cfg_sw <= 8'h08;
    online <= 1'b0;
    rd(spcu_pkg::ADDR_STATUS, v);
    chk(v[6], 1'b1);
    chk(link_en, 1'b0);
    wr(spcu_pkg::ADDR_CTRL, 32'h0000_0001);
    wr(spcu_pkg::ADDR_DATA, 32'h0000_005C);
    repeat (600) @(posedge core_clk);
    rd(spcu_pkg::ADDR_DATA, v);
    chk(v[7:0], 8'h5C);
    wr(spcu_pkg::ADDR_CTRL, 32'h0000_0000);
    @(posedge core_clk);
    online <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk({link_en, term_led}, 2'h3);
    rd(spcu_pkg::ADDR_STATUS, v);
    chk(v[6], 1'b0);
    @(posedge core_clk);
    cpu_run <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk({link_en, term_led}, 2'h0);
    summarize();
  end
endmodule
`default_nettype wire
